// [bench/opvcl_host_model.sv]
/*
  Open-drain host that sends frames on the shared line, with the pull-up.
  Assumes the slave's pull-down enable and one rising-edge clock.
*/
`timescale 1ns/1ps
`default_nettype none

module opvcl_host_model #(
  parameter int VALID_CYC = 8,
  parameter int PULSE_CYC = 50
) (
  // Clock and pins
  input wire logic core_clk,
  input wire logic ack_pulldown_oe,
  output logic line
);
  logic pull_low_q = 1'b1;

  // The pull-up wins unless either side pulls the wire low.
  assign line = !(pull_low_q || ack_pulldown_oe);

  task automatic drive(input logic low, input int n);
    pull_low_q <= low;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic send_frame(input logic [15:0] w, input int k, input int bad, output logic ack);
    int lo;
    drive(1'b0, 6 * k);
    for (int i = 15; i >= 0; i--) begin
      if (i == 7) begin
        drive(1'b1, 6 * k);
        drive(1'b0, 6 * k);
      end
      lo = w[i] ? 3 * k : 6 * k;
      if (i == bad) lo = 4 * k;
      drive(1'b1, lo);
      drive(1'b0, 9 * k - lo);
    end
    drive(1'b1, VALID_CYC + 4);
    drive(1'b0, 2);
    ack = !line;
    drive(1'b0, PULSE_CYC + 10);
  endtask
endmodule // opvcl_host_model

`default_nettype wire

// [bench/opvcl_top_asserts.sv]
/*
  Checker of the link slave's behaviour at its ports.
  Assumes it is bound to opvcl_top and sees its synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module opvcl_top_asserts #(
  parameter logic [15:0] TIMEOUT_CYC = 16'h00C8,
  parameter logic [15:0] ACK_PULSE_CYC = 16'h0032,
  parameter logic [15:0] ACK_VALID_CYC = 16'h0008
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Line, pins and settings
  input wire logic line_in,
  input wire logic ack_pulldown_out,
  input wire logic ack_pulldown_oe,
  input wire logic analog_variant,
  input wire logic conv1_select_pin,
  input wire logic [4:0] converter1_voltage_setting,
  input wire logic [4:0] converter1_alt_setting,
  input wire logic [4:0] converter2_voltage_setting,
  input wire logic [4:0] conv1_active_setting,
  // Mode and status
  input wire logic forced_pwm,
  input wire logic frame_accepted
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Run lengths: line low, pull-down on, and time since the last accepted frame.
  logic [15:0] low_cnt_q;
  logic [15:0] oe_cnt_q;
  logic [15:0] fa_cnt_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n || line_in) low_cnt_q <= 16'h0000;
    else if (low_cnt_q != 16'hFFFF) low_cnt_q <= low_cnt_q + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !ack_pulldown_oe) oe_cnt_q <= 16'h0000;
    else oe_cnt_q <= oe_cnt_q + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) fa_cnt_q <= 16'hFFFF;
    else if (frame_accepted) fa_cnt_q <= 16'h0000;
    else if (fa_cnt_q != 16'hFFFF) fa_cnt_q <= fa_cnt_q + 16'h0001;
  end

  // ==========================================================================
  // Properties
  a_pulldown_low: assert property (ack_pulldown_out == 1'b0)
    else $error("pull-down drives a high level");
  a_pwm_on_high: assert property (line_in [*4] |-> forced_pwm)
    else $error("line high but power save still allowed");
  a_pwm_in_frame: assert property (frame_accepted |-> forced_pwm)
    else $error("power save allowed during reception");
  a_save_not_early: assert property ($fell(forced_pwm) |-> low_cnt_q >= TIMEOUT_CYC - 16'h0002)
    else $error("power save before the low timeout");
  a_save_in_time: assert property (low_cnt_q == TIMEOUT_CYC + 16'h0004 |-> !forced_pwm)
    else $error("power save late after the low timeout");
  a_ack_width: assert property ($fell(ack_pulldown_oe) |-> oe_cnt_q == ACK_PULSE_CYC)
    else $error("acknowledge pulse has the wrong length");
  a_ack_bounded: assert property (ack_pulldown_oe |-> oe_cnt_q < ACK_PULSE_CYC)
    else $error("acknowledge pulse too long");
  a_ack_delay: assert property ($rose(ack_pulldown_oe) |->
    fa_cnt_q inside {[ACK_VALID_CYC - 16'h0003 : ACK_VALID_CYC + 16'h0001]})
    else $error("acknowledge not one validity delay after a good frame");
  // Settings show one cycle after the accept pulse; a variant change remaps the alternate output.
  a_set_accepted: assert property ($changed({converter1_voltage_setting, converter1_alt_setting,
    converter2_voltage_setting}) |-> $past(frame_accepted) || ($past(analog_variant) != $past(analog_variant, 2)))
    else $error("setting changed without an accepted frame");
  a_alt_analog: assert property (analog_variant && $past(analog_variant) && $past(analog_variant, 2) |->
    $stable(converter1_alt_setting))
    else $error("alternate setting written in analog variant");
endmodule // opvcl_top_asserts

`default_nettype wire

// [bench/testbench.sv]
/*
  Self-checking bench of the link slave with a host model on the line.
  Assumes shortened timing parameters and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [15:0] TMO = 16'h00C8;
  localparam logic [15:0] PULSE = 16'h0032;
  localparam logic [15:0] VALID = 16'h0008;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic analog_variant = 1'b0;
  logic conv1_select_pin = 1'b0;
  logic line, oe, pd_out, pwm, acc, ack;
  logic [4:0] c1, ca, c2, act;
  logic [4:0] e1 = 5'h00;
  logic [4:0] ea = 5'h00;
  logic [4:0] e2 = 5'h00;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int accepts = 0;

  initial forever #12.5 core_clk = !core_clk;

  opvcl_top #(.TIMEOUT_CYC(TMO), .ACK_PULSE_CYC(PULSE), .ACK_VALID_CYC(VALID)) opvcl_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .line_in(line), .ack_pulldown_out(pd_out),
    .ack_pulldown_oe(oe), .analog_variant(analog_variant), .conv1_select_pin(conv1_select_pin),
    .converter1_voltage_setting(c1), .converter1_alt_setting(ca), .converter2_voltage_setting(c2),
    .conv1_active_setting(act), .forced_pwm(pwm), .frame_accepted(acc));

  opvcl_host_model #(.VALID_CYC(VALID), .PULSE_CYC(PULSE)) opvcl_host_model_i (
    .core_clk(core_clk), .ack_pulldown_oe(oe), .line(line));

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      wrap_up();
    end
  end

  // Counts the one-cycle accept pulses while a frame is on the line.
  always @(posedge core_clk) begin
    if (acc === 1'b1) accepts++;
  end

  // The alternate output reads its reset value in the analog variant.
  task automatic regs_chk;
    chk({c1, ca, c2, act}, {e1, analog_variant ? 5'h00 : ea, e2,
      (!analog_variant && conv1_select_pin) ? ea : e1});
  endtask

  // A frame that expects no acknowledge is followed by a long low so the receiver drops any partial frame.
  task automatic frame(input logic [15:0] w, input int k, input int bad, input logic ack_exp, input logic acc_exp);
    int n0;
    n0 = accepts;
    opvcl_host_model_i.send_frame(w, k, bad, ack);
    chk({19'h00000, ack}, {19'h00000, ack_exp});
    chk(20'(accepts - n0), {19'h00000, acc_exp});
    if (!ack_exp) opvcl_host_model_i.drive(1'b1, TMO + 10);
    regs_chk();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk({c1, ca, c2, act}, 20'h00000);
    chk({17'h00000, oe, pd_out, pwm}, 20'h00000);
  endtask

  task automatic t_writes;
    e1 = 5'h15;
    frame({8'h4E, 8'h95}, 1, -1, 1'b1, 1'b1);
    e2 = 5'h0A;
    frame({8'h4E, 8'h4A}, 3, -1, 1'b0, 1'b1);
    ea = 5'h1F;
    frame({8'h4E, 8'hBF}, 1, -1, 1'b1, 1'b1);
    conv1_select_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    regs_chk();
  endtask

  task automatic t_refused;
    frame({8'h4E, 8'hE7}, 1, -1, 1'b0, 1'b1);
    frame({8'h4F, 8'h81}, 1, -1, 1'b0, 1'b0);
    frame({8'h72, 8'h81}, 1, -1, 1'b0, 1'b0);
    frame({8'h4E, 8'h82}, 1, 3, 1'b0, 1'b0);
  endtask

  task automatic t_analog;
    analog_variant <= 1'b1;
    e1 = 5'h11;
    frame({8'h4E, 8'h91}, 1, -1, 1'b1, 1'b1);
    frame({8'h4E, 8'hBC}, 1, -1, 1'b1, 1'b1);
    analog_variant <= 1'b0;
  endtask

  task automatic t_mode;
    opvcl_host_model_i.drive(1'b0, 10);
    chk({19'h00000, pwm}, 20'h00001);
    opvcl_host_model_i.drive(1'b1, TMO + 10);
    chk({19'h00000, pwm}, 20'h00000);
    opvcl_host_model_i.drive(1'b0, 10);
    opvcl_host_model_i.drive(1'b1, 20);
    frame({8'h4E, 8'h83}, 1, -1, 1'b0, 1'b0);
    e1 = 5'h03;
    frame({8'h4E, 8'h83}, 1, -1, 1'b1, 1'b1);
    opvcl_host_model_i.drive(1'b1, TMO + 10);
    chk({19'h00000, pwm}, 20'h00000);
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_writes();
    t_refused();
    t_analog();
    t_mode();
    wrap_up();
  end
endmodule // testbench

bind opvcl_top opvcl_top_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .ACK_PULSE_CYC(ACK_PULSE_CYC),
  .ACK_VALID_CYC(ACK_VALID_CYC)) opvcl_top_asserts_i (.core_clk(core_clk), .rst_n(rst_n),
  .line_in(line_in), .ack_pulldown_out(ack_pulldown_out), .ack_pulldown_oe(ack_pulldown_oe),
  .analog_variant(analog_variant), .conv1_select_pin(conv1_select_pin),
  .converter1_voltage_setting(converter1_voltage_setting), .converter1_alt_setting(converter1_alt_setting),
  .converter2_voltage_setting(converter2_voltage_setting), .conv1_active_setting(conv1_active_setting),
  .forced_pwm(forced_pwm), .frame_accepted(frame_accepted));

`default_nettype wire

// [rtl/opvcl_bit_timer.sv]
/*
  Low and high time measurement of the shared line, bit classification and
  level timeouts.
  Assumes line_in is synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "opvcl_map.svh"

module opvcl_bit_timer #(
  parameter logic [15:0] TIMEOUT_CYC = 16'(`OPVCL_TIMEOUT_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Line and control
  input wire logic line_in,
  input wire logic restart,
  // Results
  output logic fall_pulse,
  output logic bit_val,
  output logic bit_ok,
  output logic low_timeout,
  output logic high_timeout
);

  logic line_q;
  opvcl_pkg::opvcl_count_type low_cnt_q;
  opvcl_pkg::opvcl_count_type high_cnt_q;
  logic fall;
  logic is_one;
  logic is_zero;

  assign fall = line_q & ~line_in;
  assign is_one = ({1'b0, high_cnt_q} >= {low_cnt_q, 1'b0}) && (low_cnt_q != 16'h0000);
  assign is_zero = ({1'b0, low_cnt_q} >= {high_cnt_q, 1'b0}) && (high_cnt_q != 16'h0000);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      line_q <= 1'b0;
    end else begin
      line_q <= line_in;
    end
  end

  // ========================================================================
  // Period counters: a falling edge closes one period and opens the next.
  always_ff @(posedge core_clk) begin
    if (!rst_n || restart) begin
      low_cnt_q <= 16'h0000;
      high_cnt_q <= 16'h0000;
    end else if (fall) begin // see RULE_02
      low_cnt_q <= 16'h0001;
      high_cnt_q <= 16'h0000;
    end else if (!line_in) begin
      if (low_cnt_q != 16'hFFFF) begin
        low_cnt_q <= low_cnt_q + 16'h0001;
      end
    end else if (high_cnt_q != 16'hFFFF) begin
      high_cnt_q <= high_cnt_q + 16'h0001;
    end
  end

  // ========================================================================
  // Classification of the period that the edge has just closed.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fall_pulse <= 1'b0;
      bit_val <= 1'b0;
      bit_ok <= 1'b0;
      low_timeout <= 1'b0;
      high_timeout <= 1'b0;
    end else begin
      fall_pulse <= fall && !restart;
      bit_val <= is_one; // see RULE_01
      bit_ok <= is_one | is_zero; // see RULE_01
      low_timeout <= !line_in && !restart && (low_cnt_q == TIMEOUT_CYC - 16'h0001); // see RULE_13
      high_timeout <= line_in && !restart && (high_cnt_q == TIMEOUT_CYC - 16'h0001);
    end
  end

endmodule // opvcl_bit_timer

`default_nettype wire

// [rtl/opvcl_map.svh]
/*
  Constants of the one-pin voltage configuration link: field positions, codes,
  reset values and timing figures.
  Assumes a 40 MHz core clock and is included by the bit timer and the top module only.
*/
`ifndef OPVCL_MAP_SVH
`define OPVCL_MAP_SVH

// Overview of operation
// RULE_01: High time at least twice low reads one; low at least twice high reads zero.
// RULE_02: A bit period runs from one falling edge to the next falling edge.
// RULE_03: Acknowledge only on request, matching address and sixteen good bits.
// RULE_04: Acknowledge pulls the line low for at most 520 microseconds.
// RULE_05: The pull-down turns on after a validity delay from the last edge.
// RULE_06: Host keeps the line low during the validity delay.
// RULE_07: Host releases the line after the delay and reads low as accepted.
// RULE_08: Mismatch or bad frame leaves the pull-down off.
// RULE_09: Host starts no new traffic until the acknowledge pulse has ended.
// RULE_10: Only an open-drain host may request an acknowledge.
// RULE_11: Acknowledge output is active low and open drain, pulled up by host.
// RULE_12: Line high forces fixed-frequency mode, held through frame reception.
// RULE_13: A falling edge starts decoding; low for the timeout enables power save.
// RULE_14: A frame sent within the timeout after a mode edge is discarded.
// RULE_15: Host sends frames first and selects power save only afterwards.
// RULE_16: First byte is the fixed address 4E, sent most significant bit first.
// RULE_17: Second byte: acknowledge request bit 7, select bits 6 and 5, setting 4 to 0.
// RULE_18: Analog variant: select 00 writes converter 1; no alternate register.
// RULE_19: Select 01 is converter 1 alternate, 10 converter 2, 11 reserved.
// RULE_20: Every byte is sent most significant bit first.
// RULE_21: Host applies a start time before each byte and end-of-stream after it.
// RULE_22: Low-level timeout for power save is at most 520 microseconds.
// RULE_23: Settings change only after a complete, good, matching frame.
// RULE_24: Bit and byte counters restart at each start or timeout.

// ==========================================================================
// Frame layout
`define OPVCL_DEV_ADDR 8'h4E
`define OPVCL_ACK_REQ_POS 7
`define OPVCL_SEL_HI_POS 6
`define OPVCL_SEL_LO_POS 5
`define OPVCL_SET_MSB 4
`define OPVCL_BYTE_LAST_BIT 5'h07
`define OPVCL_FRAME_LAST_BIT 5'h0F

// ==========================================================================
// Register select codes and reset values
`define OPVCL_SEL_CONV1 2'h0
`define OPVCL_SEL_CONV1_ALT 2'h1
`define OPVCL_SEL_CONV2 2'h2
`define OPVCL_SEL_RSVD 2'h3
`define OPVCL_CONV1_RST 5'h00
`define OPVCL_CONV1_ALT_RST 5'h00
`define OPVCL_CONV2_RST 5'h00

// ==========================================================================
// Timing
`define OPVCL_CLK_MHZ 40
`define OPVCL_TIMEOUT_US 520
`define OPVCL_TIMEOUT_CYC (`OPVCL_TIMEOUT_US * `OPVCL_CLK_MHZ)
`define OPVCL_ACK_PULSE_US 520
`define OPVCL_ACK_PULSE_CYC (`OPVCL_ACK_PULSE_US * `OPVCL_CLK_MHZ)
`define OPVCL_ACK_VALID_US 2
`define OPVCL_ACK_VALID_CYC (`OPVCL_ACK_VALID_US * `OPVCL_CLK_MHZ)

`endif

// [rtl/opvcl_pkg.sv]
/*
  Types of the one-pin voltage configuration link.
  Assumes nothing of its surroundings.
*/
package opvcl_pkg;

  // ========================================================================
  // Receiver states, Gray coded along idle, bits, gap, bits, delay, pulse.
  typedef enum logic [2:0] {
    OPVCL_IDLE = 3'h0,
    OPVCL_BITS = 3'h1,
    OPVCL_GAP = 3'h3,
    OPVCL_ACK_DELAY = 3'h5,
    OPVCL_ACK_PULSE = 3'h4
  } opvcl_state_type;

  typedef logic [4:0] opvcl_setting_type;
  typedef logic [15:0] opvcl_count_type;

endpackage

// [rtl/opvcl_top.sv]
/*
  Slave end of the one-pin voltage configuration link: frame reception,
  address check, setting registers, acknowledge pull-down and mode selection.
  Assumes the shared line is sampled synchronously and that an external
  pull-up resistor returns the line high when nobody pulls it low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "opvcl_map.svh"

module opvcl_top #(
  parameter logic [15:0] TIMEOUT_CYC = 16'(`OPVCL_TIMEOUT_CYC),
  parameter logic [15:0] ACK_PULSE_CYC = 16'(`OPVCL_ACK_PULSE_CYC),
  parameter logic [15:0] ACK_VALID_CYC = 16'(`OPVCL_ACK_VALID_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Shared mode and data line
  input wire logic line_in,
  output logic ack_pulldown_out,
  output logic ack_pulldown_oe,
  // Variant and converter 1 select pin
  input wire logic analog_variant,
  input wire logic conv1_select_pin,
  // Settings
  output logic [4:0] converter1_voltage_setting,
  output logic [4:0] converter1_alt_setting,
  output logic [4:0] converter2_voltage_setting,
  output logic [4:0] conv1_active_setting,
  // Mode and status
  output logic forced_pwm,
  output logic frame_accepted
);

  // ========================================================================
  // Declarations
  opvcl_pkg::opvcl_state_type state_q;
  opvcl_pkg::opvcl_state_type state_d;
  logic [4:0] bit_cnt_q;
  logic [14:0] shift_q;
  logic frame_ok_q;
  logic ack_go_q;
  opvcl_pkg::opvcl_count_type dly_q;
  opvcl_pkg::opvcl_setting_type setting_q [3];
  logic fall_pulse;
  logic bit_val;
  logic bit_ok;
  logic low_timeout;
  logic high_timeout;
  logic restart;
  logic last_bit;
  logic [15:0] frame_word;
  logic frame_good;
  logic write_en;
  logic [1:0] sel;

  // True when select code sel writes the register at slot idx.
  function automatic logic sel_hits(input logic [1:0] code, input logic [1:0] idx, input logic analog);
    sel_hits = (code == idx) && (code != `OPVCL_SEL_RSVD) &&
      !(analog && code == `OPVCL_SEL_CONV1_ALT);
  endfunction

  // ========================================================================
  // Line timing and bit classification
  opvcl_bit_timer #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_bit_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .line_in(line_in),
    .restart(restart),
    .fall_pulse(fall_pulse),
    .bit_val(bit_val),
    .bit_ok(bit_ok),
    .low_timeout(low_timeout),
    .high_timeout(high_timeout)
  );

  // ========================================================================
  // Frame decode
  // The last bit arrives with the edge, so the frame is judged from the
  // shift register plus the incoming bit.
  assign last_bit = (state_q == opvcl_pkg::OPVCL_BITS) && fall_pulse &&
    (bit_cnt_q == `OPVCL_FRAME_LAST_BIT);
  assign frame_word = {shift_q, bit_val}; // see RULE_20
  assign frame_good = frame_ok_q && bit_ok &&
    (frame_word[15:8] == `OPVCL_DEV_ADDR); // see RULE_16
  assign sel = frame_word[`OPVCL_SEL_HI_POS:`OPVCL_SEL_LO_POS]; // see RULE_17
  assign write_en = last_bit && frame_good; // see RULE_23
  // Timers restart when the acknowledge pulse ends, so our own pull-down
  // does not count as host low time.
  assign restart = (state_q == opvcl_pkg::OPVCL_ACK_PULSE) &&
    (state_d == opvcl_pkg::OPVCL_IDLE);

  // ========================================================================
  // Receiver state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      opvcl_pkg::OPVCL_IDLE: begin
        // Any falling edge, including a mode change edge, opens a bit.
        if (fall_pulse) begin // see RULE_14
          state_d = opvcl_pkg::OPVCL_BITS;
        end
      end
      opvcl_pkg::OPVCL_BITS: begin
        if (low_timeout || high_timeout) begin // see RULE_24
          state_d = opvcl_pkg::OPVCL_IDLE;
        end else if (fall_pulse && bit_cnt_q == `OPVCL_BYTE_LAST_BIT) begin
          state_d = opvcl_pkg::OPVCL_GAP;
        end else if (last_bit) begin
          state_d = opvcl_pkg::OPVCL_ACK_DELAY;
        end
      end
      opvcl_pkg::OPVCL_GAP: begin
        // The gap holds end-of-stream low and start high; its edge opens byte two.
        if (low_timeout) begin // see RULE_24
          state_d = opvcl_pkg::OPVCL_IDLE;
        end else if (fall_pulse) begin
          state_d = opvcl_pkg::OPVCL_BITS;
        end
      end
      opvcl_pkg::OPVCL_ACK_DELAY: begin
        if (dly_q == ACK_VALID_CYC - 16'h0001) begin // see RULE_05
          state_d = ack_go_q ? opvcl_pkg::OPVCL_ACK_PULSE : opvcl_pkg::OPVCL_IDLE; // see RULE_08
        end
      end
      opvcl_pkg::OPVCL_ACK_PULSE: begin
        if (dly_q == ACK_PULSE_CYC - 16'h0001) begin // see RULE_04
          state_d = opvcl_pkg::OPVCL_IDLE;
        end
      end
      default: begin
        state_d = opvcl_pkg::OPVCL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= opvcl_pkg::OPVCL_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ========================================================================
  // Bit counter, shift register and frame quality
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 15'h0000;
      frame_ok_q <= 1'b0;
    end else if (state_q == opvcl_pkg::OPVCL_IDLE) begin
      bit_cnt_q <= 5'h00; // see RULE_24
      frame_ok_q <= 1'b1;
    end else if (state_q == opvcl_pkg::OPVCL_BITS && fall_pulse) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      shift_q <= {shift_q[13:0], bit_val}; // see RULE_20
      frame_ok_q <= frame_ok_q & bit_ok;
    end
  end

  // ========================================================================
  // Acknowledge decision
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_go_q <= 1'b0;
    end else if (last_bit) begin
      ack_go_q <= frame_good && frame_word[`OPVCL_ACK_REQ_POS] && (sel != `OPVCL_SEL_RSVD); // see RULE_03
    end
  end

  // ========================================================================
  // Delay counter, restarted on every state change
  always_ff @(posedge core_clk) begin
    if (!rst_n || state_d != state_q) begin
      dly_q <= 16'h0000;
    end else if (dly_q != 16'hFFFF) begin
      dly_q <= dly_q + 16'h0001;
    end
  end

  // ========================================================================
  // Setting registers
  generate
    for (genvar i = 0; i < 3; i++) begin : g_setting
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          setting_q[i] <= (i == 0) ? `OPVCL_CONV1_RST : (i == 1) ? `OPVCL_CONV1_ALT_RST : `OPVCL_CONV2_RST;
        end else if (write_en && sel_hits(sel, 2'(i), analog_variant)) begin // see RULE_18, see RULE_19
          setting_q[i] <= frame_word[`OPVCL_SET_MSB:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      converter1_voltage_setting <= `OPVCL_CONV1_RST;
      converter1_alt_setting <= `OPVCL_CONV1_ALT_RST;
      converter2_voltage_setting <= `OPVCL_CONV2_RST;
      conv1_active_setting <= `OPVCL_CONV1_RST;
    end else begin
      converter1_voltage_setting <= setting_q[0];
      converter1_alt_setting <= analog_variant ? `OPVCL_CONV1_ALT_RST : setting_q[1]; // see RULE_18
      converter2_voltage_setting <= setting_q[2];
      conv1_active_setting <= (!analog_variant && conv1_select_pin) ? setting_q[1] : setting_q[0];
    end
  end

  // ========================================================================
  // Mode selection
  // A high line forces fixed frequency at once; only a full low timeout,
  // which never occurs inside a well formed frame, returns to power save.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      forced_pwm <= 1'b0;
    end else if (line_in) begin
      forced_pwm <= 1'b1; // see RULE_12
    end else if (low_timeout) begin
      forced_pwm <= 1'b0; // see RULE_13, see RULE_22
    end
  end

  // ========================================================================
  // Acknowledge pull-down and status
  // The pin is only ever pulled low; the pull-up gives the high level.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_pulldown_out <= 1'b0;
      ack_pulldown_oe <= 1'b0;
      frame_accepted <= 1'b0;
    end else begin
      ack_pulldown_out <= 1'b0; // see RULE_11
      ack_pulldown_oe <= (state_d == opvcl_pkg::OPVCL_ACK_PULSE); // see RULE_04
      frame_accepted <= write_en;
    end
  end

endmodule // opvcl_top

`default_nettype wire
